// >>> rtl/eti_pkg.sv
// shared constants and types of the edge timestamp input logger
package eti_pkg;

   // geometry
   localparam int          CH_NUM          = 4;
   localparam int          ENTRY_MAX_SMALL = 5;
   localparam int          ENTRY_MAX_LARGE = 15;
   localparam int          ENTRY_W         = 32;
   localparam int          DIAG_BYTES      = 20;
   localparam int          DIAG_HEAD_BYTES = 4;
   localparam int          PARAM_BYTES     = 8;
   localparam int          CLK_MHZ         = 125;
   localparam int          CNT_W           = 19;
   localparam logic [7:0]  SEQ_STEP        = 8'h01;
   localparam logic [CNT_W-1:0] CNT_STEP    = 19'h00001;

   // fixed image lengths
   localparam logic [7:0]  IMG_LEN_SMALL   = 8'h14;
   localparam logic [7:0]  IMG_LEN_LARGE   = 8'h3C;
   localparam logic [7:0]  OUT_IMG_LEN     = 8'h00;

   // filter delay codes and their times in microseconds
   localparam logic [7:0]  DLY_CODE_1      = 8'h00;
   localparam logic [7:0]  DLY_CODE_3      = 8'h02;
   localparam logic [7:0]  DLY_CODE_10     = 8'h04;
   localparam logic [7:0]  DLY_CODE_86     = 8'h07;
   localparam logic [7:0]  DLY_CODE_342    = 8'h09;
   localparam logic [7:0]  DLY_CODE_2731   = 8'h0C;
   localparam logic [7:0]  DLY_CODE_RESET  = DLY_CODE_3;
   localparam int          DLY_US_1        = 1;
   localparam int          DLY_US_3        = 3;
   localparam int          DLY_US_10       = 10;
   localparam int          DLY_US_86       = 86;
   localparam int          DLY_US_342      = 342;
   localparam int          DLY_US_2731     = 2731;
   localparam int          DLY_CYC_1       = DLY_US_1 * CLK_MHZ;
   localparam int          DLY_CYC_3       = DLY_US_3 * CLK_MHZ;
   localparam int          DLY_CYC_10      = DLY_US_10 * CLK_MHZ;
   localparam int          DLY_CYC_86      = DLY_US_86 * CLK_MHZ;
   localparam int          DLY_CYC_342     = DLY_US_342 * CLK_MHZ;
   localparam int          DLY_CYC_2731    = DLY_US_2731 * CLK_MHZ;

   // edge select layout
   localparam logic [3:0]  EDGE_SEL_RESET  = 4'h0;

   // diagnostic record contents
   localparam logic [7:0]  DIAG_FAULT      = 8'h00;
   localparam logic [7:0]  DIAG_MODULE     = 8'h1F;
   localparam logic [7:0]  DIAG_CHTYPE     = 8'h70;
   localparam logic [7:0]  DIAG_DIAG_BITS_PER_CHANNEL     = 8'h00;
   localparam logic [7:0]  DIAG_CHANNEL_COUNT      = 8'h04;
   localparam int          DIAG_B_MODULE   = 1;
   localparam int          DIAG_B_CHTYPE   = 4;
   localparam int          DIAG_B_DIAG_BITS_PER_CHANNEL   = 5;
   localparam int          DIAG_B_CHANNEL_COUNT    = 6;
   localparam int          DIAG_B_STAMP    = 16;

   // parameter byte positions
   localparam int          PAR_B_INLEN     = 0;
   localparam int          PAR_B_OUTLEN    = 1;
   localparam int          PAR_B_DELAY0    = 2;
   localparam int          PAR_B_RISE      = 6;
   localparam int          PAR_B_FALL      = 7;

   // access path addressing
   localparam logic [7:0]  REC_DIAG_HEAD   = 8'h00;
   localparam logic [7:0]  REC_DIAG        = 8'h01;
   localparam logic [7:0]  REC_DELAY       = 8'h01;
   localparam logic [7:0]  REC_LENGTH      = 8'h02;
   localparam logic [7:0]  REC_EDGE        = 8'h80;
   localparam logic [15:0] IDX_DIAG_HEAD   = 16'h2F00;
   localparam logic [15:0] IDX_DIAG        = 16'h2F01;
   localparam logic [15:0] IDX_PARAM_BASE  = 16'h3100;
   localparam logic [15:0] IDX_DIAG_SUB    = 16'h5005;
   localparam logic [7:0]  SUB_PARAM_BASE  = 8'h01;
   localparam logic [7:0]  SUB_DIAG_BASE   = 8'h02;
   localparam logic [7:0]  SUB_STAMP_BASE  = 8'h13;

   typedef enum logic [1:0] {PATH_RECORD, PATH_INDEX, PATH_SUB} eti_path_t;
   typedef enum logic [1:0] {TGT_NONE, TGT_PARAM, TGT_DIAG} eti_kind_t;

   typedef struct packed {
      logic              valid;
      logic              write;
      eti_path_t         path;
      logic [15:0]       index;
      logic [7:0]        sub;
      logic [7:0]        data;
   } eti_req_t;

   typedef struct packed {
      logic              valid;
      logic              error;
      logic [7:0]        data;
   } eti_rsp_t;

   typedef struct packed {
      eti_kind_t         kind;
      logic [4:0]        sel;
   } eti_tgt_t;

endpackage

// >>> rtl/eti_logger.sv
// four-channel filtered edge timestamp logger with parameter and diagnostic access
// Functional notes
// - Image holds 5 entries in 20 bytes or 15 entries in 60 bytes.
// - Input image length reads 14h or 3Ch by variant, never changeable.
// - Output image length is fixed at zero bytes.
// - Per-channel delay codes 00h,02h,04h,07h,09h,0Ch; others invalid; default 02h.
// - Delay filters short spikes before edges are evaluated.
// - Rising select bit n enables entries on channel n rising edges.
// - Falling select bit n enables entries on channel n falling edges.
// - Both edge selects reset to zero.
// - Enabled edge captures low 16 bits of microsecond timer and all input states.
// - New entry lands at offset 0; older entries move up 4 bytes.
// - When full, the oldest entry is discarded.
// - No interrupts; diagnostics are read-only information.
// - Record 01h gives full diagnostics, record 00h its first 4 bytes.
// - Index 2F01h gives full diagnostics, 2F00h its first 4 bytes.
// - Diagnostic bytes are subentries of object 5005h.
// - Parameters are objects 3100h upward, one per byte.
// - Module info holds class 1111b and info-present bit; reads 1Fh.
// - Channel type reads 70h with bit 7 zero.
// - Diagnostics report zero bits per channel and four channels.
// - Diagnostic ticker field holds ticker sampled at record generation.
`timescale 1ns/1ps

module eti_logger
   import eti_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1,
   parameter int DLY_CYC_86_P   = DLY_CYC_86,
   parameter int DLY_CYC_342_P  = DLY_CYC_342,
   parameter int DLY_CYC_2731_P = DLY_CYC_2731
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // field inputs
   input  wire logic [CH_NUM-1:0] digitalInputChan,
   // microsecond ticker from head module
   input  wire logic [31:0]       tickerUs,
   // parameter and diagnostic access
   input  wire eti_req_t          accessReq,
   output      eti_rsp_t          accessRsp,
   // input image read
   input  wire logic              imageRead,
   input  wire logic [5:0]        imageAddr,
   output      logic              imageValid,
   output      logic [7:0]        imageData,
   // filtered input states
   output      logic [CH_NUM-1:0] inputState
);

   localparam int          ENTRY_CAP = LARGE_VARIANT ? ENTRY_MAX_LARGE : ENTRY_MAX_SMALL;
   localparam logic [7:0]  IMG_LEN   = LARGE_VARIANT ? IMG_LEN_LARGE : IMG_LEN_SMALL;

   typedef struct packed {
      logic [CH_NUM-1:0]                         sync1;
      logic [CH_NUM-1:0]                         sync2;
      logic [CH_NUM-1:0]                         sync3;
      logic [CH_NUM-1:0]                         stable;
      logic [CH_NUM-1:0]                         filt;
      logic [CH_NUM-1:0][CNT_W-1:0]              cnt;
      logic [CH_NUM-1:0][7:0]                    delay;
      logic [3:0]                                rise;
      logic [3:0]                                fall;
      logic [ENTRY_MAX_LARGE-1:0][ENTRY_W-1:0]   entry;
      logic [7:0]                                seq;
      logic [31:0]                               stamp;
      eti_rsp_t                                  rsp;
      logic                                      imgValid;
      logic [7:0]                                imgData;
   } eti_state_t;

   eti_state_t st;
   eti_state_t next_st;

   function automatic logic codeValid(input logic [7:0] code);
      return (code == DLY_CODE_1) || (code == DLY_CODE_3) || (code == DLY_CODE_10) ||
             (code == DLY_CODE_86) || (code == DLY_CODE_342) || (code == DLY_CODE_2731);
   endfunction

   function automatic logic [CNT_W-1:0] delayCycles(input logic [7:0] code);
      int c;
      c = DLY_CYC_3;
      unique case (code)
         DLY_CODE_1:    c = DLY_CYC_1;
         DLY_CODE_10:   c = DLY_CYC_10;
         DLY_CODE_86:   c = DLY_CYC_86_P;
         DLY_CODE_342:  c = DLY_CYC_342_P;
         DLY_CODE_2731: c = DLY_CYC_2731_P;
         default:       c = DLY_CYC_3;
      endcase
      if (c < 1)
         c = 1;
      return c[CNT_W-1:0];
   endfunction

   // resolve an access to a parameter or diagnostic byte
   function automatic eti_tgt_t decode(input eti_req_t r);
      eti_tgt_t t;
      t.kind = TGT_NONE;
      t.sel  = 5'h00;
      unique case (r.path)
         PATH_RECORD:
         begin
            if (!r.write && (r.index[7:0] == REC_DIAG_HEAD) && (r.sub < 8'(DIAG_HEAD_BYTES)))
            begin
               t.kind = TGT_DIAG;
               t.sel  = r.sub[4:0];
            end
            else if (!r.write && (r.index[7:0] == REC_DIAG) && (r.sub < 8'(DIAG_BYTES)))
            begin
               t.kind = TGT_DIAG;
               t.sel  = r.sub[4:0];
            end
            else if (r.write && (r.index[7:0] == REC_DELAY) && (r.sub < 8'(CH_NUM)))
            begin
               t.kind = TGT_PARAM;
               t.sel  = 5'(PAR_B_DELAY0) + r.sub[4:0];
            end
            else if ((r.index[7:0] == REC_LENGTH) && (r.sub < 8'(PAR_B_DELAY0)))
            begin
               t.kind = TGT_PARAM;
               t.sel  = r.sub[4:0];
            end
            else if ((r.index[7:0] == REC_EDGE) && (r.sub < 8'(PAR_B_FALL - PAR_B_RISE + 1)))
            begin
               t.kind = TGT_PARAM;
               t.sel  = 5'(PAR_B_RISE) + r.sub[4:0];
            end
         end
         PATH_INDEX:
         begin
            if (!r.write && (r.index == IDX_DIAG_HEAD) && (r.sub < 8'(DIAG_HEAD_BYTES)))
            begin
               t.kind = TGT_DIAG;
               t.sel  = r.sub[4:0];
            end
            else if (!r.write && (r.index == IDX_DIAG) && (r.sub < 8'(DIAG_BYTES)))
            begin
               t.kind = TGT_DIAG;
               t.sel  = r.sub[4:0];
            end
            else if ((r.index >= IDX_PARAM_BASE) &&
                     (r.index < IDX_PARAM_BASE + 16'(PARAM_BYTES)))
            begin
               t.kind = TGT_PARAM;
               t.sel  = 5'(r.index - IDX_PARAM_BASE);
            end
         end
         PATH_SUB:
         begin
            if (!r.write && (r.index == IDX_DIAG_SUB) && (r.sub >= SUB_DIAG_BASE) &&
                (r.sub < SUB_DIAG_BASE + 8'(DIAG_B_STAMP)))
            begin
               t.kind = TGT_DIAG;
               t.sel  = 5'(r.sub - SUB_DIAG_BASE);
            end
            else if (!r.write && (r.index == IDX_DIAG_SUB) && (r.sub >= SUB_STAMP_BASE) &&
                     (r.sub < SUB_STAMP_BASE + 8'(DIAG_BYTES - DIAG_B_STAMP)))
            begin
               t.kind = TGT_DIAG;
               t.sel  = 5'(DIAG_B_STAMP) + 5'(r.sub - SUB_STAMP_BASE);
            end
            else if ((r.index == IDX_PARAM_BASE) && (r.sub >= SUB_PARAM_BASE) &&
                     (r.sub < SUB_PARAM_BASE + 8'(PARAM_BYTES)))
            begin
               t.kind = TGT_PARAM;
               t.sel  = 5'(r.sub - SUB_PARAM_BASE);
            end
         end
         default:
         begin
            t.kind = TGT_NONE;
         end
      endcase
      return t;
   endfunction

   always_comb
   begin
      eti_tgt_t          tgt;
      logic [CH_NUM-1:0] nextFilt;
      logic [CH_NUM-1:0] risen;
      logic [CH_NUM-1:0] fallen;
      logic              record;
      logic [3:0]        idx;
      tgt      = decode(accessReq);
      nextFilt = st.filt;
      risen    = '0;
      fallen   = '0;
      record   = 1'b0;
      idx      = 4'h0;
      next_st  = st;

      // input synchroniser, qualified when stages two and three agree
      next_st.sync1 = digitalInputChan;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      for (int i = 0; i < CH_NUM; i++)
      begin
         if (st.sync2[i] == st.sync3[i])
            next_st.stable[i] = st.sync3[i];
      end

      for (int i = 0; i < CH_NUM; i++)
      begin
         if (st.stable[i] != st.filt[i])
         begin
            if (st.cnt[i] + CNT_STEP >= delayCycles(st.delay[i]))
            begin
               nextFilt[i]    = st.stable[i];
               next_st.cnt[i] = '0;
            end
            else
               next_st.cnt[i] = st.cnt[i] + CNT_STEP;
         end
         else
            next_st.cnt[i] = '0;
      end
      next_st.filt = nextFilt;
      risen        = nextFilt & ~st.filt;
      fallen       = ~nextFilt & st.filt;

      record = |((risen & st.rise) | (fallen & st.fall));

      if (record)
      begin
         // shift older entries up, oldest drops out
         for (int i = ENTRY_MAX_LARGE - 1; i > 0; i--)
         begin
            if (i < ENTRY_CAP)
               next_st.entry[i] = st.entry[i-1];
         end
         next_st.entry[0] = {tickerUs[15:0], st.seq, 4'h0, nextFilt};
         next_st.seq      = st.seq + SEQ_STEP;
      end

      // input image byte read
      next_st.imgValid = imageRead;
      next_st.imgData  = 8'h00;
      idx              = imageAddr[5:2];
      if (imageRead && ({2'b00, imageAddr} < IMG_LEN) && (int'(idx) < ENTRY_CAP))
         next_st.imgData = st.entry[idx][8*imageAddr[1:0] +: 8];

      // parameter and diagnostic access, answered next cycle
      next_st.rsp.valid = accessReq.valid;
      next_st.rsp.error = 1'b0;
      next_st.rsp.data  = 8'h00;
      if (accessReq.valid)
      begin
         unique case (tgt.kind)
            TGT_PARAM:
            begin
               if (accessReq.write)
               begin
                  if (int'(tgt.sel) == PAR_B_INLEN)
                     next_st.rsp.error = (accessReq.data != IMG_LEN);
                  else if (int'(tgt.sel) == PAR_B_OUTLEN)
                     next_st.rsp.error = (accessReq.data != OUT_IMG_LEN);
                  else if (int'(tgt.sel) == PAR_B_RISE)
                     next_st.rise = accessReq.data[3:0];
                  else if (int'(tgt.sel) == PAR_B_FALL)
                     next_st.fall = accessReq.data[3:0];
                  else if (codeValid(accessReq.data))
                     next_st.delay[2'(tgt.sel - 5'(PAR_B_DELAY0))] = accessReq.data;
                  else
                     next_st.rsp.error = 1'b1;
               end
               else
               begin
                  if (int'(tgt.sel) == PAR_B_INLEN)
                     next_st.rsp.data = IMG_LEN;
                  else if (int'(tgt.sel) == PAR_B_OUTLEN)
                     next_st.rsp.data = OUT_IMG_LEN;
                  else if (int'(tgt.sel) == PAR_B_RISE)
                     next_st.rsp.data = {4'h0, st.rise};
                  else if (int'(tgt.sel) == PAR_B_FALL)
                     next_st.rsp.data = {4'h0, st.fall};
                  else
                     next_st.rsp.data = st.delay[2'(tgt.sel - 5'(PAR_B_DELAY0))];
               end
            end
            TGT_DIAG:
            begin
               // ticker snapshot when record generation starts
               if (tgt.sel == 5'h00)
                  next_st.stamp = tickerUs;
               if (int'(tgt.sel) == DIAG_B_MODULE)
                  next_st.rsp.data = DIAG_MODULE;
               else if (int'(tgt.sel) == DIAG_B_CHTYPE)
                  next_st.rsp.data = DIAG_CHTYPE;
               else if (int'(tgt.sel) == DIAG_B_DIAG_BITS_PER_CHANNEL)
                  next_st.rsp.data = DIAG_DIAG_BITS_PER_CHANNEL;
               else if (int'(tgt.sel) == DIAG_B_CHANNEL_COUNT)
                  next_st.rsp.data = DIAG_CHANNEL_COUNT;
               else if (int'(tgt.sel) >= DIAG_B_STAMP)
                  next_st.rsp.data = st.stamp[8*(2'(tgt.sel - 5'(DIAG_B_STAMP))) +: 8];
               else
                  next_st.rsp.data = DIAG_FAULT;
            end
            default:
            begin
               next_st.rsp.error = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st       <= '0;
         st.delay <= {CH_NUM{DLY_CODE_RESET}};
         st.rise  <= EDGE_SEL_RESET;
         st.fall  <= EDGE_SEL_RESET;
      end
      else
         st <= next_st;
   end

   assign accessRsp  = st.rsp;
   assign imageValid = st.imgValid;
   assign imageData  = st.imgData;
   assign inputState = st.filt;

endmodule

// >>> test/eti_head_model.sv
// head module model supplying the microsecond ticker
`timescale 1ns/1ps

module eti_head_model
   import eti_pkg::*;
#(
   parameter logic [31:0] TICK_BASE = 32'h1234_5600
)
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // ticker to the logger
   output      logic [31:0] tickerUs
);
   int preDiv;

   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         preDiv   <= 0;
         tickerUs <= TICK_BASE;
      end
      else if (preDiv == CLK_MHZ - 1)
      begin
         preDiv   <= 0;
         tickerUs <= tickerUs + 32'h1;
      end
      else
         preDiv <= preDiv + 1;
   end
endmodule

// >>> test/eti_logger_checker.sv
// port assertions of the edge timestamp input logger
`timescale 1ns/1ps

module eti_logger_checker
   import eti_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
)
(
   // clock and reset
   input wire logic              clk,
   input wire logic              sys_rst,
   // field inputs and ticker
   input wire logic [CH_NUM-1:0] digitalInputChan,
   input wire logic [31:0]       tickerUs,
   // access port
   input wire eti_req_t          accessReq,
   input wire eti_rsp_t          accessRsp,
   // image port and states
   input wire logic              imageRead,
   input wire logic [5:0]        imageAddr,
   input wire logic              imageValid,
   input wire logic [7:0]        imageData,
   input wire logic [CH_NUM-1:0] inputState
);
   localparam logic [7:0] IMG_LEN = LARGE_VARIANT ? IMG_LEN_LARGE : IMG_LEN_SMALL;
   logic rdIdx;
   logic diagRd;
   assign rdIdx  = accessReq.valid && !accessReq.write && accessReq.path == PATH_INDEX;
   assign diagRd = rdIdx && accessReq.index == IDX_DIAG;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   rsp_timing_a: assert property (accessReq.valid |=> accessRsp.valid)
      else $error("access answer missing");
   rsp_cause_a: assert property (accessRsp.valid |-> $past(accessReq.valid))
      else $error("access answer without request");
   img_timing_a: assert property (imageRead |=> imageValid)
      else $error("image answer missing");
   img_cause_a: assert property (imageValid |-> $past(imageRead))
      else $error("image answer without request");
   img_beyond_a: assert property (imageRead && imageAddr >= IMG_LEN |=> imageData == 8'h00)
      else $error("image byte beyond length not zero");
   in_len_a: assert property (rdIdx && accessReq.index == 16'h3100 |=> accessRsp.data == IMG_LEN)
      else $error("input length wrong");
   out_len_a: assert property (rdIdx && accessReq.index == 16'h3101 |=> accessRsp.data == 8'h00)
      else $error("output length wrong");
   mod_info_a: assert property (diagRd && accessReq.sub == 8'h01 |=> accessRsp.data == 8'h1F)
      else $error("module info wrong");
   chan_type_a: assert property (diagRd && accessReq.sub == 8'h04 |=> accessRsp.data == 8'h70)
      else $error("channel type wrong");
   chan_count_a: assert property (diagRd && accessReq.sub == 8'h06 |=> accessRsp.data == 8'h04)
      else $error("channel count wrong");
   diag_ro_a: assert property (accessReq.valid && accessReq.write && accessReq.path != PATH_RECORD
      && accessReq.index == IDX_DIAG ##1 1'b1 |-> accessRsp.error)
      else $error("diagnostic write accepted");
   spike_filter_a: assert property ($changed(inputState) |-> ((inputState ^ $past(inputState)) & ($past(digitalInputChan, 8) ^ inputState)) == 4'h0)
      else $error("filtered state changed without held input");

   cover property (accessRsp.valid && accessRsp.error);
   cover property (imageValid && imageData != 8'h00);
   cover property ($changed(inputState));
endmodule

bind eti_logger eti_logger_checker #(.LARGE_VARIANT(LARGE_VARIANT)) chk (
   .clk(clk), .sys_rst(sys_rst), .digitalInputChan(digitalInputChan), .tickerUs(tickerUs),
   .accessReq(accessReq), .accessRsp(accessRsp), .imageRead(imageRead),
   .imageAddr(imageAddr), .imageValid(imageValid), .imageData(imageData),
   .inputState(inputState));

// >>> test/eti_logger_tb.sv
// self-checking testbench of the edge timestamp input logger
`timescale 1ns/1ps

module eti_logger_tb;
   import eti_pkg::*;
   logic              clk;
   logic              sys_rst;
   logic [CH_NUM-1:0] digitalInputChan;
   logic [31:0]       tickerUs;
   eti_req_t          accessReq;
   eti_rsp_t          accessRsp;
   eti_rsp_t          rspSmall;
   logic [7:0]        imgSmall;
   logic [31:0]       snap;
   logic              imageRead;
   logic [5:0]        imageAddr;
   logic              imageValid;
   logic [7:0]        imageData;
   logic [CH_NUM-1:0] inputState;
   int                err_count;
   int                checked;
   int                cycles;
   logic [31:0]       lastTick;
   logic [7:0]        rd;
   logic [7:0]        expQ[$];
   logic [7:0]        byt[4];
   logic [7:0]        seq0;
   logic [15:0]       prevTk;
   logic [3:0]        cv;
   logic [3:0]        nv;
   logic [7:0]        codes[6] = '{8'h00, 8'h02, 8'h04, 8'h07, 8'h09, 8'h0C};

   eti_logger #(.LARGE_VARIANT(1'b1), .DLY_CYC_86_P(20), .DLY_CYC_342_P(40),
                .DLY_CYC_2731_P(60)) dut (
      .clk(clk), .sys_rst(sys_rst), .digitalInputChan(digitalInputChan),
      .tickerUs(tickerUs), .accessReq(accessReq), .accessRsp(accessRsp),
      .imageRead(imageRead), .imageAddr(imageAddr), .imageValid(imageValid),
      .imageData(imageData), .inputState(inputState));

   // small variant shares every input
   eti_logger #(.LARGE_VARIANT(1'b0), .DLY_CYC_86_P(20), .DLY_CYC_342_P(40),
                .DLY_CYC_2731_P(60)) dutSmall (
      .clk(clk), .sys_rst(sys_rst), .digitalInputChan(digitalInputChan),
      .tickerUs(tickerUs), .accessReq(accessReq), .accessRsp(rspSmall),
      .imageRead(imageRead), .imageAddr(imageAddr), .imageValid(),
      .imageData(imgSmall), .inputState());

   eti_head_model head (.clk(clk), .sys_rst(sys_rst), .tickerUs(tickerUs));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 40000)
      begin
         err_count++;
         $display("timeout");
         give_verdict();
      end
   end

   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic acc(input logic wr, input eti_path_t p, input logic [15:0] idx,
                      input logic [7:0] sb, input logic [7:0] wd, output logic e);
      @(posedge clk);
      accessReq <= '{1'b1, wr, p, idx, sb, wd};
      @(negedge clk);
      lastTick = tickerUs;
      @(posedge clk);
      accessReq.valid <= 1'b0;
      @(negedge clk);
      rd = accessRsp.data;
      e = accessRsp.error;
      check("answer valid", {7'h0, accessRsp.valid}, 8'h01);
   endtask

   task automatic rdc(input eti_path_t p, input logic [15:0] idx, input logic [7:0] sb,
                      input logic [7:0] exp);
      logic e;
      acc(1'b0, p, idx, sb, 8'h00, e);
      check("read data", rd, exp);
      check("read error", {7'h0, e}, 8'h00);
   endtask

   task automatic wrc(input eti_path_t p, input logic [15:0] idx, input logic [7:0] sb,
                      input logic [7:0] wd, input logic expErr);
      logic e;
      acc(1'b1, p, idx, sb, wd, e);
      check("write error", {7'h0, e}, {7'h0, expErr});
   endtask

   task automatic img(input logic [5:0] a, output logic [7:0] d);
      @(posedge clk);
      imageRead <= 1'b1;
      imageAddr <= a;
      @(posedge clk);
      imageRead <= 1'b0;
      @(negedge clk);
      check("image valid", {7'h0, imageValid}, 8'h01);
      d = imageData;
   endtask

   function automatic logic [7:0] dexp(int b);
      return (b == 1) ? 8'h1F : (b == 4) ? 8'h70 : (b == 6) ? 8'h04 : 8'h00;
   endfunction

   task automatic settle(int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   initial
   begin
      sys_rst = 1'b1;
      digitalInputChan = 4'h0;
      accessReq = '0;
      imageRead = 1'b0;
      imageAddr = 6'h00;
      err_count = 0;
      checked = 0;
      cycles = 0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++)
         rdc(PATH_INDEX, 16'h3100 + 16'(i), 8'h00, (i == 0) ? 8'h3C : (i > 1 && i < 6) ? 8'h02 : 8'h00);
      rdc(PATH_RECORD, 16'h0002, 8'h00, 8'h3C);
      rdc(PATH_SUB, 16'h3100, 8'h08, 8'h00);
      $display("test reset_values done");
      for (int i = 0; i < 16; i++)
      begin
         rdc(PATH_INDEX, IDX_DIAG, 8'(i), dexp(i));
         rdc(PATH_RECORD, 16'h0001, 8'(i), dexp(i));
         rdc(PATH_SUB, IDX_DIAG_SUB, 8'(i + 2), dexp(i));
         if (i < 4)
            rdc(PATH_INDEX, IDX_DIAG_HEAD, 8'(i), dexp(i));
         if (i < 4)
            rdc(PATH_RECORD, 16'h0000, 8'(i), dexp(i));
      end
      rdc(PATH_RECORD, 16'h0001, 8'h00, 8'h00);
      snap = lastTick;
      for (int i = 0; i < 4; i++)
      begin
         rdc(PATH_RECORD, 16'h0001, 8'(16 + i), 8'(snap >> (8 * i)));
         rdc(PATH_SUB, IDX_DIAG_SUB, 8'(8'h13 + i), 8'(snap >> (8 * i)));
      end
      $display("test diagnostics done");
      foreach (codes[i])
      begin
         wrc(PATH_INDEX, 16'h3103, 8'h00, codes[i], 1'b0);
         rdc(PATH_SUB, 16'h3100, 8'h04, codes[i]);
      end
      wrc(PATH_RECORD, 16'h0001, 8'h01, 8'h01, 1'b1);
      rdc(PATH_INDEX, 16'h3103, 8'h00, 8'h0C);
      wrc(PATH_INDEX, 16'h3100, 8'h00, 8'h14, 1'b1);
      rdc(PATH_INDEX, 16'h3100, 8'h00, 8'h3C);
      check("small length", rspSmall.data, 8'h14);
      wrc(PATH_RECORD, 16'h0002, 8'h00, 8'h3C, 1'b0);
      wrc(PATH_SUB, 16'h3100, 8'h02, 8'h01, 1'b1);
      rdc(PATH_RECORD, 16'h0002, 8'h01, 8'h00);
      wrc(PATH_INDEX, IDX_DIAG, 8'h01, 8'h00, 1'b1);
      $display("test parameters done");
      // ch0 fastest code, ch1 keeps code 0Ch
      wrc(PATH_INDEX, 16'h3102, 8'h00, 8'h07, 1'b0);
      digitalInputChan <= 4'h1;
      repeat (10) @(posedge clk);
      digitalInputChan <= 4'h0;
      settle(40);
      check("filtered state", {4'h0, inputState}, 8'h00);
      digitalInputChan <= 4'h1;
      settle(40);
      check("filtered state", {4'h0, inputState}, 8'h01);
      digitalInputChan <= 4'h0;
      settle(40);
      img(6'h00, rd);
      check("entry state", rd, 8'h00);
      $display("test filter done");
      wrc(PATH_RECORD, 16'h0080, 8'h00, 8'hF1, 1'b0);
      rdc(PATH_INDEX, 16'h3106, 8'h00, 8'h01);
      wrc(PATH_SUB, 16'h3100, 8'h08, 8'h02, 1'b0);
      cv = 4'h8;
      digitalInputChan <= cv;
      settle(DLY_CYC_3 + 30);
      for (int j = 1; j <= 32; j++)
      begin
         nv = {2'b10, 2'(j)};
         if ((nv & ~cv & 4'h1) != 4'h0 || (cv & ~nv & 4'h2) != 4'h0)
            expQ.push_front({4'h0, nv});
         cv = nv;
         digitalInputChan <= nv;
         settle(260);
         check("filtered state", {4'h0, inputState}, {4'h0, nv});
      end
      prevTk = tickerUs[15:0] + 16'h1;
      for (int k = 0; k < 16; k++)
      begin
         for (int b = 0; b < 4; b++)
         begin
            img(6'(4 * k + b), byt[b]);
            if (b == 0 || k >= 5)
               check("small image", imgSmall, (k < 5) ? expQ[k] : 8'h00);
         end
         if (k == 0)
            seq0 = byt[1];
         if (k < 15)
         begin
            check("entry state", byt[0], expQ[k]);
            check("entry number", byt[1], 8'(seq0 - 8'(k)));
            check("entry stamp order", {7'h0, {byt[3], byt[2]} < prevTk}, 8'h01);
            prevTk = {byt[3], byt[2]};
         end
         else
            check("beyond image", byt[0] | byt[1] | byt[2] | byt[3], 8'h00);
      end
      $display("test entries done");
      give_verdict();
   end
endmodule
